// [src/can_xcvr_consts.svh]
// Constants for the CAN transceiver mode and wake control block
`ifndef CAN_XCVR_CONSTS_SVH
`define CAN_XCVR_CONSTS_SVH

`define CLK_MHZ          40

// Chip operating mode codes
`define MODE_OFF         3'h0
`define MODE_SLEEP       3'h1
`define MODE_FAILSAFE    3'h2
`define MODE_RESET       3'h3
`define MODE_STANDBY     3'h4
`define MODE_OVERLOAD    3'h5
`define MODE_FORCED      3'h6
`define MODE_NORMAL      3'h7

// Transceiver mode field encodings
`define MF_OFFLINE       2'h0
`define MF_ACT_UV        2'h1
`define MF_ACT_NOUV      2'h2
`define MF_LISTEN        2'h3
`define SHDN_NONE        2'h0

// Register indices; byte address is four times the index
`define IDX_XCVR_CTRL    6'h20
`define IDX_XCVR_STAT    6'h21
`define IDX_FRAME_CTRL   6'h26
`define IDX_PN_BASE      6'h28
`define IDX_PN_MASK      6'h38
`define IDX_IDENT_B      6'h29
`define IDX_IDENT_C      6'h2A
`define IDX_MASK_B       6'h2D

// Field positions
`define CTRL_MF_LSB      0
`define CTRL_WAKE_EN     2
`define CTRL_SEL_EN      3
`define CTRL_CFG_OK      4
`define CTRL_SHDN_LSB    5
`define STAT_WAKE        3
`define STAT_TX_RDY      4
`define FRAME_FMT        0
`define STD_ID_LSB       10
`define STD_ID_MSB       20

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define PIN_RST          6'h01

// Bus wake timing
`define T_WAKE_DOM_NS    1000
`define T_WAKE_REC_NS    1000
`define WAKE_TIMEOUT_US     1000
`define SILENCE_TIMEOUT_US  1000
`define WAKE_DOM_CYC     ((`T_WAKE_DOM_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_REC_CYC     ((`T_WAKE_REC_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_TO_CYC      (`WAKE_TIMEOUT_US * `CLK_MHZ)
`define SILENCE_CYC      (`SILENCE_TIMEOUT_US * `CLK_MHZ)
`define PH_W             8

`endif

// [src/can_xcvr_pkg.sv]
// Types shared by the CAN transceiver control files
package can_xcvr_pkg;

   typedef enum logic [2:0] {
      XS_OFF, XS_OFFLINE, XS_BIAS, XS_LISTEN, XS_ACTIVE
   } xcvr_state_t;

   typedef enum logic [1:0] {
      WP_IDLE, WP_DOM1, WP_REC, WP_DOM2
   } wake_phase_t;

endpackage : can_xcvr_pkg

// [src/timeout_timer.sv]
// Restartable timeout counter running on the on-chip oscillator clock
`timescale 1ns/1ps

module timeout_timer #(
   parameter int unsigned TERM = 16
) (
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   input  wire logic restart_i,
   output logic      expired_o
);
   localparam int unsigned W = $clog2(TERM + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         exp;
   } tmr_t;

   tmr_t q;
   tmr_t d;

   always_comb begin
      d = q;
      if (restart_i) begin
         d.cnt = '0;
         d.exp = 1'b0;
      end else if (!q.exp) begin
         if (q.cnt >= W'(TERM - 1)) begin
            d.exp = 1'b1;
         end else begin
            d.cnt = q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired_o = q.exp;

endmodule : timeout_timer

// [src/can_xcvr_mode_ctrl.sv]
// CAN transceiver mode sequencing, bus wake detection and register slave
`timescale 1ns/1ps
`include "can_xcvr_consts.svh"

// Contract
// RULE_01: In Normal mode, mode field 01 or 10 requests Active.
// RULE_02: Field 01 leaves Active for Offline/Bias on supply undervoltage.
// RULE_03: Field 10 ignores supply undervoltage; only regulator reset ends Active.
// RULE_04: Code 111 is Normal; Forced Normal with good supply is Active too.
// RULE_05: Transmit pin low turns an Active request into Listen-only.
// RULE_06: Listen-only for field 11 in Normal/Standby or Forced with undervoltage.
// RULE_07: Listen-only holds while field 01 is set and supply stays low.
// RULE_08: Standby and Sleep force Offline or Offline Bias by bus activity; code gives Listen-only in Standby with field 11.
// RULE_09: Offline watches for wake-up only when wake enable is set.
// RULE_10: Bus activity biases; silence beyond timeout returns to Offline.
// RULE_11: Leaving Active/Listen goes Offline, via Bias if bus was active.
// RULE_12: Off or overtemperature into Reset places transceiver Offline.
// RULE_13: Wake pattern, or field 01 undervoltage in Normal, biases Offline.
// RULE_14: Off, overload, shutdown or supply loss floats; recovery gives Offline.
// RULE_15: Pattern detection when wake enabled and selective wake not valid.
// RULE_16: Waking party sends dominant, recessive, dominant within wake timeout.
// RULE_17: Valid wake sets wake status, pulls receive pin low, wakes sleep.
// RULE_18: Wake frames watched only with all three enables set.
// RULE_19: Format bit selects 11-bit or 29-bit wake identifiers.
// RULE_20: Identifier compared ignoring bits whose mask bit is one.
// RULE_21: Standard identifier spans bytes 0x29/0x2A; low mask bits in 0x2D.
// RULE_22: Bus activity while inactive biases the bus regardless of supply.
// RULE_23: Any partial-networking register write clears configuration valid.
// RULE_24: Silence and wake timeouts are restartable oscillator counters.
module can_xcvr_mode_ctrl #(
   parameter int unsigned SILENCE_CYC = `SILENCE_CYC,
   parameter int unsigned WAKE_TO_CYC = `WAKE_TO_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [2:0]  chip_mode_code_i,
   input  wire logic        tx_data_pin_i,
   input  wire logic        bus_dominant_i,
   input  wire logic        xcvr_supply_uv_i,
   input  wire logic        main_reg_uv_i,
   input  wire logic        bat_smps_uv_i,
   input  wire logic        shutdown_cond_i,
   input  wire logic [28:0] rx_ident_i,
   input  wire logic        rx_ident_ext_i,
   input  wire logic        rx_ident_valid_i,
   output logic             tx_enable_o,
   output logic             rx_enable_o,
   output logic             bias_enable_o,
   output logic             bus_float_o,
   output logic             rx_data_pin_o,
   output logic             wake_event_o,
   output logic             sleep_wake_o,
   output logic [2:0]       xcvr_state_o,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp
);
   localparam int unsigned DOM_CYC = `WAKE_DOM_CYC;
   localparam int unsigned REC_CYC = `WAKE_REC_CYC;

   typedef struct packed {
      logic [5:0]                  s1;
      logic [5:0]                  s2;
      logic [5:0]                  s3;
      logic [5:0]                  pin;
      logic                        dom_last;
      can_xcvr_pkg::xcvr_state_t   xst;
      can_xcvr_pkg::wake_phase_t   wph;
      logic [`PH_W-1:0]            pc;
      logic [2:0]                  prev_mode;
      logic [7:0][7:0]             pn;
      logic [1:0]                  mf;
      logic                        wake_en;
      logic                        sel_en;
      logic                        cfg_ok;
      logic [1:0]                  shdn;
      logic                        fmt;
      logic                        wake_st;
      logic                        rx;
      logic                        wake_p;
      logic                        sleep_p;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
   } ctrl_t;

   ctrl_t q;
   ctrl_t d;

   logic        txd_hi, dom, vuv, muv, bsuv, shc;
   logic        normal, forced, standby, sleep;
   logic        off_cond, active_req, listen_req, hold_listen, uv_bias;
   logic        reset_from_off, bus_edge, silent, wake_exp;
   logic        wake_arm, pn_mode, std_en, std_hit, sel_hit, wake_hit;
   logic [31:0] id_w, mask_w;
   logic        id_match;
   logic        wr_go, rd_go, pn_wr;
   logic [5:0]  widx;
   logic [8:0]  rd_val, wr_map;

   // Filtered pin levels; a change counts once the last two stages agree
   assign {shc, bsuv, muv, vuv, dom, txd_hi} = q.pin;

   assign normal  = chip_mode_code_i == `MODE_NORMAL;            // [RULE_04]
   assign forced  = chip_mode_code_i == `MODE_FORCED;
   assign standby = chip_mode_code_i == `MODE_STANDBY;
   assign sleep   = chip_mode_code_i == `MODE_SLEEP;             // [RULE_08]

   assign off_cond = chip_mode_code_i == `MODE_OFF
                   || chip_mode_code_i == `MODE_OVERLOAD
                   || (q.shdn != `SHDN_NONE && shc)
                   || bsuv;                                      // [RULE_14]
   assign active_req = (normal && ((q.mf == `MF_ACT_UV && !vuv)  // [RULE_01]
                      || (q.mf == `MF_ACT_NOUV && !muv)))        // [RULE_03]
                      || (forced && !vuv);                       // [RULE_04]
   assign listen_req = ((normal || standby) && q.mf == `MF_LISTEN)
                     || (forced && vuv);                         // [RULE_06]
   assign uv_bias = normal && q.mf == `MF_ACT_UV && vuv;         // [RULE_13]
   assign hold_listen = q.xst == can_xcvr_pkg::XS_LISTEN
                      && uv_bias;                                // [RULE_07]
   // Overload code also stands for overtemperature shutdown
   assign reset_from_off = chip_mode_code_i == `MODE_RESET
                         && (q.prev_mode == `MODE_OFF
                         || q.prev_mode == `MODE_OVERLOAD);      // [RULE_12]
   assign bus_edge = q.pin[1] != q.dom_last;

   // Silence window restarts on every bus edge
   timeout_timer #(.TERM(SILENCE_CYC)) silence_tmr (             // [RULE_24]
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .restart_i  (bus_edge),
      .expired_o  (silent)
   );

   // Whole pattern must finish inside one window from its first dominant
   timeout_timer #(.TERM(WAKE_TO_CYC)) wake_tmr (                // [RULE_24]
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .restart_i  (q.wph == can_xcvr_pkg::WP_IDLE),
      .expired_o  (wake_exp)
   );

   assign wake_arm = (q.xst == can_xcvr_pkg::XS_OFFLINE
                   || q.xst == can_xcvr_pkg::XS_BIAS) && q.wake_en; // [RULE_09]
   assign pn_mode = q.sel_en && q.cfg_ok;
   assign std_en  = wake_arm && !pn_mode;                        // [RULE_15]
   assign std_hit = std_en && !wake_exp && dom
                  && q.wph == can_xcvr_pkg::WP_DOM2
                  && q.pc >= `PH_W'(DOM_CYC - 1);                // [RULE_16]

   assign id_w   = {q.pn[3], q.pn[2], q.pn[1], q.pn[0]};
   assign mask_w = {q.pn[7], q.pn[6], q.pn[5], q.pn[4]};
   // Standard identifier sits in bits 20..10: upper bits of 0x29 and low bits of 0x2A
   always_comb begin
      if (q.fmt) begin                                           // [RULE_19]
         id_match = ((rx_ident_i ^ id_w[28:0])
                    & ~mask_w[28:0]) == 29'h0;                   // [RULE_20]
      end else begin
         id_match = ((rx_ident_i[10:0] ^ id_w[`STD_ID_MSB:`STD_ID_LSB])
                    & ~mask_w[`STD_ID_MSB:`STD_ID_LSB]) == 11'h0; // [RULE_21]
      end
   end
   assign sel_hit = wake_arm && pn_mode && rx_ident_valid_i
                  && rx_ident_ext_i == q.fmt && id_match;        // [RULE_18]
   assign wake_hit = std_hit || sel_hit;

   function automatic logic [8:0] reg_rd(input logic [5:0] idx);
      logic [8:0] r;
      r = 9'h100;
      if ((idx & `IDX_PN_MASK) == `IDX_PN_BASE) begin
         r[7:0] = q.pn[idx[2:0]];
      end else if (idx == `IDX_XCVR_CTRL) begin
         r[`CTRL_MF_LSB +: 2]   = q.mf;
         r[`CTRL_WAKE_EN]       = q.wake_en;
         r[`CTRL_SEL_EN]        = q.sel_en;
         r[`CTRL_CFG_OK]        = q.cfg_ok;
         r[`CTRL_SHDN_LSB +: 2] = q.shdn;
      end else if (idx == `IDX_XCVR_STAT) begin
         r[2:0]            = q.xst;
         r[`STAT_WAKE]     = q.wake_st;
         r[`STAT_TX_RDY]   = q.xst == can_xcvr_pkg::XS_ACTIVE;
      end else if (idx == `IDX_FRAME_CTRL) begin
         r[`FRAME_FMT] = q.fmt;
      end else begin
         r = 9'h000;
      end
      return r;
   endfunction : reg_rd

   // Address and data are taken together, one write outstanding
   assign wr_go  = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
   assign rd_go  = s_axi_arvalid && !q.rvalid;
   assign widx   = s_axi_awaddr[7:2];
   // A process, not assigns, so the map follows every state change it reads
   always_comb begin
      wr_map = reg_rd(widx);
      rd_val = reg_rd(s_axi_araddr[7:2]);
   end
   assign pn_wr  = wr_go && s_axi_wstrb[0]
                 && ((widx & `IDX_PN_MASK) == `IDX_PN_BASE
                 || widx == `IDX_FRAME_CTRL);

   always_comb begin
      d = q;
      d.s1 = {shutdown_cond_i, bat_smps_uv_i, main_reg_uv_i,
              xcvr_supply_uv_i, bus_dominant_i, tx_data_pin_i};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.pin = (q.pin & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
      d.dom_last = q.pin[1];
      d.prev_mode = chip_mode_code_i;

      // Transceiver state
      if (off_cond) begin
         d.xst = can_xcvr_pkg::XS_OFF;                           // [RULE_14]
      end else if (q.xst == can_xcvr_pkg::XS_OFF || reset_from_off) begin
         d.xst = can_xcvr_pkg::XS_OFFLINE;                       // [RULE_12]
      end else if (active_req && txd_hi) begin
         d.xst = can_xcvr_pkg::XS_ACTIVE;                        // [RULE_01]
      end else if (active_req || listen_req || hold_listen) begin
         d.xst = can_xcvr_pkg::XS_LISTEN;                        // [RULE_05]
      end else if (q.xst == can_xcvr_pkg::XS_OFFLINE) begin
         // Biasing needs no transceiver supply, so activity alone does it
         d.xst = (bus_edge || std_hit || uv_bias)                // [RULE_22]
               ? can_xcvr_pkg::XS_BIAS
               : can_xcvr_pkg::XS_OFFLINE;                       // [RULE_13]
      end else begin
         d.xst = (silent && !uv_bias)                            // [RULE_10]
               ? can_xcvr_pkg::XS_OFFLINE
               : can_xcvr_pkg::XS_BIAS;                          // [RULE_11]
      end

      // Wake pattern; off-phase pulses only pause the phase count
      if (!std_en || wake_exp) begin
         d.wph = can_xcvr_pkg::WP_IDLE;
         d.pc  = '0;
      end else begin
         unique case (q.wph)
            can_xcvr_pkg::WP_IDLE: begin
               if (dom) begin
                  d.wph = can_xcvr_pkg::WP_DOM1;
                  d.pc  = `PH_W'(1);
               end
            end
            can_xcvr_pkg::WP_DOM1: begin
               if (dom && q.pc >= `PH_W'(DOM_CYC - 1)) begin
                  d.wph = can_xcvr_pkg::WP_REC;
                  d.pc  = '0;
               end else if (dom) begin
                  d.pc = q.pc + `PH_W'(1);
               end
            end
            can_xcvr_pkg::WP_REC: begin
               if (!dom && q.pc >= `PH_W'(REC_CYC - 1)) begin
                  d.wph = can_xcvr_pkg::WP_DOM2;                 // [RULE_16]
                  d.pc  = '0;
               end else if (!dom) begin
                  d.pc = q.pc + `PH_W'(1);
               end
            end
            can_xcvr_pkg::WP_DOM2: begin
               if (std_hit) begin
                  d.wph = can_xcvr_pkg::WP_IDLE;
                  d.pc  = '0;
               end else if (dom) begin
                  d.pc = q.pc + `PH_W'(1);
               end
            end
         endcase
      end

      // Register writes
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp  = wr_map[8] ? `RESP_OKAY : `RESP_SLVERR;
         if (s_axi_wstrb[0] && wr_map[8]) begin
            if ((widx & `IDX_PN_MASK) == `IDX_PN_BASE) begin
               d.pn[widx[2:0]] = s_axi_wdata[7:0];
            end else if (widx == `IDX_FRAME_CTRL) begin
               d.fmt = s_axi_wdata[`FRAME_FMT];
            end else if (widx == `IDX_XCVR_CTRL) begin
               d.mf      = s_axi_wdata[`CTRL_MF_LSB +: 2];
               d.wake_en = s_axi_wdata[`CTRL_WAKE_EN];
               d.sel_en  = s_axi_wdata[`CTRL_SEL_EN];
               d.cfg_ok  = s_axi_wdata[`CTRL_CFG_OK];
               d.shdn    = s_axi_wdata[`CTRL_SHDN_LSB +: 2];
            end else if (s_axi_wdata[`STAT_WAKE]) begin
               d.wake_st = 1'b0;
            end
         end
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (pn_wr) begin
         d.cfg_ok = 1'b0;                                        // [RULE_23]
      end

      // A wake arriving with the clear still sets the flag
      if (wake_hit) begin
         d.wake_st = 1'b1;                                       // [RULE_17]
      end
      d.wake_p  = wake_hit;
      d.sleep_p = wake_hit && sleep;                             // [RULE_17]
      if (q.xst == can_xcvr_pkg::XS_ACTIVE
          || q.xst == can_xcvr_pkg::XS_LISTEN) begin
         d.rx = !dom;
      end else begin
         d.rx = !d.wake_st;                                      // [RULE_17]
      end

      // Register reads
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rdata  = {24'h000000, rd_val[7:0]};
         d.rresp  = rd_val[8] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q     <= '0;
         q.s1  <= `PIN_RST;
         q.s2  <= `PIN_RST;
         q.s3  <= `PIN_RST;
         q.pin <= `PIN_RST;
         q.xst <= can_xcvr_pkg::XS_OFFLINE;
         q.rx  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign tx_enable_o   = q.xst == can_xcvr_pkg::XS_ACTIVE;
   assign rx_enable_o   = tx_enable_o || q.xst == can_xcvr_pkg::XS_LISTEN;
   assign bias_enable_o = rx_enable_o || q.xst == can_xcvr_pkg::XS_BIAS;
   assign bus_float_o   = q.xst == can_xcvr_pkg::XS_OFF;
   assign xcvr_state_o  = q.xst;
   assign rx_data_pin_o = q.rx;
   assign wake_event_o  = q.wake_p;
   assign sleep_wake_o  = q.sleep_p;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   off_force_a: assert property (off_cond |=> bus_float_o) // [RULE_14]
      else $error("off condition did not float the bus");
   active_cause_a: assert property (tx_enable_o              // [RULE_04]
      |-> $past(active_req && txd_hi && !off_cond))
      else $error("active entered without a valid request");
   uv_active_a: assert property (normal && q.mf == `MF_ACT_UV // [RULE_02]
      && vuv && tx_enable_o && !off_cond
      |=> q.xst == can_xcvr_pkg::XS_BIAS)
      else $error("supply undervoltage did not leave active");
   nouv_keep_a: assert property (normal && q.mf == `MF_ACT_NOUV // [RULE_03]
      && !muv && txd_hi && !off_cond
      && q.xst != can_xcvr_pkg::XS_OFF |=> tx_enable_o)
      else $error("field 10 lost active");
   txd_low_a: assert property (active_req && !txd_hi         // [RULE_05]
      && !off_cond && !reset_from_off && q.xst != can_xcvr_pkg::XS_OFF
      |=> q.xst == can_xcvr_pkg::XS_LISTEN && !tx_enable_o)
      else $error("low transmit pin did not give listen-only");
   listen_hold_a: assert property (hold_listen && !off_cond // [RULE_07]
      && !reset_from_off |=> q.xst == can_xcvr_pkg::XS_LISTEN)
      else $error("listen-only left under supply undervoltage");
   sleep_offline_a: assert property ((sleep || (standby     // [RULE_08]
      && q.mf != `MF_LISTEN)) && !off_cond
      |=> !rx_enable_o)
      else $error("standby or sleep left receiver enabled");
   silence_a: assert property (q.xst == can_xcvr_pkg::XS_BIAS // [RULE_10]
      && silent && !uv_bias && !active_req && !listen_req && !off_cond
      |=> q.xst == can_xcvr_pkg::XS_OFFLINE)
      else $error("silent bus did not return to offline");
   wake_flag_a: assert property (std_hit                    // [RULE_17]
      |=> q.wake_st && !rx_data_pin_o && wake_event_o)
      else $error("wake pattern not flagged on status and pin");
   wake_gate_a: assert property (!q.wake_en |-> !wake_hit)  // [RULE_09]
      else $error("wake detected while wake disabled");
   cfg_clear_a: assert property (pn_wr |=> !q.cfg_ok)       // [RULE_23]
      else $error("config valid survived a configuration write");

endmodule : can_xcvr_mode_ctrl

// [verif/can_host_model.sv]
// Host controller model: transmit pin and a bus wake pattern on request
`timescale 1ns/1ps
module can_host_model (
   input  wire logic core_clk_i,
   input  wire logic wake_go_i,
   input  wire logic tx_low_i,
   output logic      tx_data_pin_o,
   output logic      bus_dominant_o
);
   int cnt = 0;
   // 50-cycle phases clear the 40-cycle minimums even after filtering
   always @(posedge core_clk_i) begin
      if (wake_go_i && cnt == 0) cnt <= 1;
      else if (cnt != 0) cnt <= (cnt == 150) ? 0 : cnt + 1;
   end
   assign bus_dominant_o = cnt != 0 && (cnt <= 50 || cnt > 100);
   assign tx_data_pin_o  = !tx_low_i;
endmodule : can_host_model

// [verif/testbench.sv]
// Self-checking bench for the transceiver mode and wake control block
`timescale 1ns/1ps
`include "can_xcvr_consts.svh"
module testbench;
   logic        core_clk_i = 0, rst_b_i = 0, uv = 0, shd = 0, wgo = 0;
   logic        txl = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sws = 0;
   logic [2:0]  mode = `MODE_NORMAL;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rdt, rd;
   logic [1:0]  rsp, brs, rrs;
   logic        txp, dom, txe, rxe, bse, flt, rxp, wev, swk, awr, wr, bv;
   logic        arr, rv;
   logic [2:0]  st;
   logic        mv = 0, rxx = 0, rxv = 0;
   logic [28:0] rid = 0;
   int          nwk = 0;
   int          failures = 0, samples_checked = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      if (swk) sws <= 1;
      if (wev) nwk <= nwk + 1;
   end
   can_host_model host (.core_clk_i(core_clk_i), .wake_go_i(wgo),
      .tx_low_i(txl), .tx_data_pin_o(txp), .bus_dominant_o(dom));
   can_xcvr_mode_ctrl #(.SILENCE_CYC(200), .WAKE_TO_CYC(400)) uut (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .chip_mode_code_i(mode),
      .tx_data_pin_i(txp), .bus_dominant_i(dom), .xcvr_supply_uv_i(uv),
      .main_reg_uv_i(mv), .bat_smps_uv_i(1'b0), .shutdown_cond_i(shd),
      .rx_ident_i(rid), .rx_ident_ext_i(rxx), .rx_ident_valid_i(rxv),
      .tx_enable_o(txe), .rx_enable_o(rxe), .bias_enable_o(bse),
      .bus_float_o(flt), .rx_data_pin_o(rxp), .wake_event_o(wev),
      .sleep_wake_o(swk), .xcvr_state_o(st), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(brs),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdt),
      .s_axi_rresp(rrs));
   task close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : wt
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      awv <= 1; wv <= 1; awa <= a; wd <= d; br <= 1;
      do @(posedge core_clk_i); while (!(awr && wr));
      awv <= 0; wv <= 0;
      while (!bv) @(posedge core_clk_i);
      rsp = brs; br <= 0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge core_clk_i);
      arv <= 1; ara <= a; rr <= 1;
      do @(posedge core_clk_i); while (!arr);
      arv <= 0;
      while (!rv) @(posedge core_clk_i);
      rd = rdt; rsp = rrs; rr <= 0;
   endtask : axr
   task automatic t_modes;
      axw(8'h80, 32'h01); wt(8); chk("act", 4, st);
      chk("txe", 1, txe);
      txl <= 1; wt(8); chk("lis", 3, st);
      chk("rxe", 1, rxe);
      uv <= 1; wt(8); txl <= 0; wt(8); chk("hold", 3, st);
      uv <= 0; wt(8); uv <= 1; wt(8); chk("uvb", 2, st);
      axw(8'h80, 32'h02); wt(8); chk("nouv", 4, st);
      mv <= 1; wt(8); chk("mrst", 0, txe);
      mv <= 0;
      axw(8'h80, 32'h03); uv <= 0; wt(8); chk("l11", 3, st);
   endtask : t_modes
   task automatic t_standby;
      axw(8'h80, 32'h00); wt(250); chk("off00", 1, st);
      mode <= `MODE_STANDBY; axw(8'h80, 32'h01); wt(8);
      chk("sby", 1, st);
      chk("bso", 0, bse);
      wgo <= 1; wt(1); wgo <= 0; wt(20); chk("act", 2, st);
      chk("bse", 1, bse);
      wt(400); chk("sil", 1, st);
      chk("nowk", 1, rxp);
   endtask : t_standby
   task automatic t_wake;
      mode <= `MODE_SLEEP; axw(8'h80, 32'h04);
      wgo <= 1; wt(1); wgo <= 0; wt(170);
      axr(8'h84); chk("wst", 1, rd[3]);
      chk("rxd", 0, rxp); chk("slw", 1, sws);
      chk("wev", 1, nwk);
   endtask : t_wake
   task automatic t_regs;
      axw(8'h80, 32'h14); axw(8'hA4, 32'h80); axr(8'hA4);
      chk("idb", 32'h80, rd);
      axr(8'h80); chk("cfg", 0, rd[4]);
      axr(8'h00); chk("unm", `RESP_SLVERR, rsp);
      axw(8'h04, 32'h01); chk("wun", `RESP_SLVERR, rsp);
   endtask : t_regs
   task automatic pn(input logic [28:0] i, input logic x);
      rid <= i;
      rxx <= x;
      rxv <= 1;
      wt(1);
      rxv <= 0;
      wt(2);
      axr(8'h84);
   endtask : pn
   task automatic t_sel;
      axw(8'hA8, 32'h06); axw(8'hB4, 32'h1C); axw(8'h84, 32'h08);
      axw(8'h80, 32'h1C); chk("wok", `RESP_OKAY, rsp);
      pn(29'h1A8, 0); chk("pmis", 0, rd[3]);
      pn(29'h1A5, 1); chk("pfmt", 0, rd[3]);
      pn(29'h1A5, 0); chk("phit", 1, rd[3]);
      chk("pev", 2, nwk);
   endtask : t_sel
   task automatic t_off;
      mode <= `MODE_OFF; wt(4); chk("flt", 1, flt);
      mode <= `MODE_RESET; wt(4); chk("rst", 1, st);
      axw(8'h80, 32'h20); shd <= 1; wt(8); chk("shd", 1, flt);
   endtask : t_off
   initial begin
      #(25 * 6000);
      failures++;
      close_out;
   end
   initial begin
      wt(4); rst_b_i <= 1; wt(1); chk("rst", 1, st);
      t_modes; t_standby; t_wake; t_regs; t_sel; t_off;
      close_out;
   end
endmodule : testbench
